/* common/modulo_timer_pkg.sv */
// package of constants for the modulo timer block
`default_nettype none
package modulo_timer_pkg;
  // register byte offsets over apb
  localparam logic [3:0] status_control_off = 4'h0;
  localparam logic [3:0] clock_config_off = 4'h4;
  localparam logic [3:0] count_value_off = 4'h8;
  localparam logic [3:0] wrap_limit_off = 4'hc;
  // status/control field positions
  localparam int flag_bit = 7;
  localparam int irq_en_bit = 6;
  localparam int reset_bit = 5;
  localparam int halt_bit = 4;
  // clock config field positions
  localparam int src_lo = 4;
  localparam int ps_hi = 3;
  // reset values
  localparam logic [7:0] count_rst = 8'h00;
  localparam logic [7:0] wrap_rst = 8'h00;
  localparam logic [1:0] src_rst = 2'h0;
  localparam logic [3:0] ps_rst = 4'h0;
  localparam logic halt_rst = 1'b1;
  // largest prescale code
  localparam logic [3:0] ps_max = 4'h8;
  // source select codes
  typedef enum logic [1:0] {
    modulo_timer_src_bus = 2'b00,
    modulo_timer_src_fixed = 2'b01,
    modulo_timer_src_pin_fall = 2'b10,
    modulo_timer_src_pin_rise = 2'b11
  } modulo_timer_src_e;
endpackage
`default_nettype wire

/* src/modulo_timer_timer.sv */
// 8-bit modulo timer with prescaler and apb register slave
`default_nettype none
module modulo_timer_timer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic fixed_freq_clock,
  input wire logic stop_mode,
  input wire logic stop_exit_reset,
  input wire logic debug_active,
  output logic timer_irq
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  // two stages so release is synchronous to sys_clk
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // registers and decode
  logic [7:0] count;
  logic [7:0] wrap_limit;
  logic [1:0] source_select;
  logic [3:0] prescale_select;
  logic counter_halt;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic flag_seen;
  logic [7:0] presc;
  logic wr_en;
  logic rd_en;
  logic tick;
  logic wrap_now;
  logic sc_wr;
  logic mod_wr;
  logic trst_wr;
  logic soft_init;

  // access phase completes in one cycle, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign sc_wr = wr_en && paddr == modulo_timer_pkg::status_control_off;
  assign mod_wr = wr_en && paddr == modulo_timer_pkg::wrap_limit_off;
  assign trst_wr = sc_wr && pwdata[modulo_timer_pkg::reset_bit];
  // stop exit through reset reinitialises everything
  assign soft_init = stop_exit_reset;

  // decode of prescale code to a ripple tap
  function automatic logic [3:0] ps_clip(input logic [3:0] code);
    // codes above 8 saturate to divide by 256
    ps_clip = (code > modulo_timer_pkg::ps_max) ? modulo_timer_pkg::ps_max : code;
  endfunction

  // ==========================================================
  // external pin sync and edge detect
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic ff_s1;
  logic ff_s2;
  logic ff_s3;
  // two flops before any logic reads the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      ff_s1 <= 1'b0;
      ff_s2 <= 1'b0;
      ff_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_count_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ff_s1 <= fixed_freq_clock;
      ff_s2 <= ff_s1;
      ff_s3 <= ff_s2;
    end
  end

  // source edge pulse, one bus cycle wide
  logic src_pulse;
  always_comb begin
    // one pulse per qualifying synchronised edge
    case (modulo_timer_pkg::modulo_timer_src_e'(source_select))
      modulo_timer_pkg::modulo_timer_src_bus: src_pulse = 1'b1;
      modulo_timer_pkg::modulo_timer_src_fixed: src_pulse = ff_s2 && !ff_s3;
      // pin used only for the upper two codes
      modulo_timer_pkg::modulo_timer_src_pin_fall: src_pulse = !pin_s2 && pin_s3;
      modulo_timer_pkg::modulo_timer_src_pin_rise: src_pulse = pin_s2 && !pin_s3;
      default: src_pulse = 1'b1;
    endcase
  end

  // counting permitted: halted by bit, stop mode, or debug
  logic run;
  // wait mode has no input: counting simply continues
  // stop mode gates the counter regardless of settings
  assign run = !counter_halt && !stop_mode && !debug_active && !stop_exit_reset;

  // ==========================================================
  // prescaler
  logic [8:0] presc_next;
  assign presc_next = {1'b0, presc} + 9'h001;
  // tick when all low bits of the ripple reach one
  always_comb begin
    logic [3:0] tap;
    tap = ps_clip(prescale_select);
    if (tap == 4'h0) begin
      tick = run && src_pulse;
    end else begin
      tick = run && src_pulse && ((presc & ((8'h01 << tap) - 8'h01)) ==
        ((8'h01 << tap) - 8'h01));
    end
  end

  // prescaler advances on each selected source edge
  // source or ratio changes leave prescaler and counter as they are
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 8'h00;
    end else if (soft_init || trst_wr || mod_wr) begin
      presc <= 8'h00;
    end else if (run && src_pulse) begin
      presc <= presc_next[7:0];
    end
  end

  // ==========================================================
  // counter
  // wrap when count equals a nonzero limit
  // limit zero runs free through 8'hff
  assign wrap_now = tick && (wrap_limit == 8'h00 ? count == 8'hff : count == wrap_limit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= modulo_timer_pkg::count_rst;
    end else if (soft_init || trst_wr || mod_wr) begin
      count <= modulo_timer_pkg::count_rst;
    end else if (wrap_now) begin
      count <= 8'h00;
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end

  // ==========================================================
  // overflow flag with read-then-write clear
  logic flag_clr;
  // write of zero needs an earlier read seeing the flag set
  assign flag_clr = sc_wr && !pwdata[modulo_timer_pkg::flag_bit] && flag_seen;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
      flag_seen <= 1'b0;
    end else if (soft_init) begin
      overflow_flag <= 1'b0;
      flag_seen <= 1'b0;
    end else begin
      if (wrap_now) begin
        // set wins over any bus clear in the same cycle
        overflow_flag <= 1'b1;
      end else if (flag_clr || trst_wr || mod_wr) begin
        // reset bit or limit write clears flag
        overflow_flag <= 1'b0;
      end
      if (rd_en && paddr == modulo_timer_pkg::status_control_off && overflow_flag) begin
        flag_seen <= 1'b1;
      end else if (sc_wr || !overflow_flag) begin
        flag_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_irq_enable <= 1'b0;
      counter_halt <= modulo_timer_pkg::halt_rst;
      source_select <= modulo_timer_pkg::src_rst;
      prescale_select <= modulo_timer_pkg::ps_rst;
      wrap_limit <= modulo_timer_pkg::wrap_rst;
    end else if (soft_init) begin
      overflow_irq_enable <= 1'b0;
      counter_halt <= modulo_timer_pkg::halt_rst;
      source_select <= modulo_timer_pkg::src_rst;
      prescale_select <= modulo_timer_pkg::ps_rst;
      wrap_limit <= modulo_timer_pkg::wrap_rst;
    end else begin
      // low nibble of status write ignored
      if (sc_wr) begin
        overflow_irq_enable <= pwdata[modulo_timer_pkg::irq_en_bit];
        counter_halt <= pwdata[modulo_timer_pkg::halt_bit];
      end
      if (wr_en && paddr == modulo_timer_pkg::clock_config_off) begin
        source_select <= pwdata[modulo_timer_pkg::src_lo +: 2];
        prescale_select <= pwdata[modulo_timer_pkg::ps_hi:0];
      end
      if (mod_wr) begin
        wrap_limit <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // apb read data and response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // ready in the access cycle after setup
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr[1:0] != 2'b00;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          modulo_timer_pkg::status_control_off:
            prdata[7:0] <= {overflow_flag, overflow_irq_enable, 1'b0, counter_halt, 4'h0};
          modulo_timer_pkg::clock_config_off: prdata[7:0] <= {2'b00, source_select, prescale_select};
          modulo_timer_pkg::count_value_off: prdata[7:0] <= count;
          modulo_timer_pkg::wrap_limit_off: prdata[7:0] <= wrap_limit;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // interrupt request
  // irq follows flag when enabled
  // state kept over stop, so a pending irq survives interrupt exit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= overflow_flag && overflow_irq_enable && !stop_exit_reset;
    end
  end

  // ==========================================================
  // assertions
  a_wrap_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrap_now && !soft_init |=> overflow_flag && count == 8'h00)
    else $error("wrap did not set flag");
  a_trst_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trst_wr && !wrap_now |=> count == 8'h00 && !overflow_flag)
    else $error("counter reset failed");
  a_mod_write_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mod_wr && !wrap_now |=> count == 8'h00 && !overflow_flag && wrap_limit == $past(pwdata[7:0]))
    else $error("modulo write failed");
  a_halt_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    counter_halt && !trst_wr && !mod_wr && !soft_init |=> $stable(count))
    else $error("count moved while halted");
  a_stop_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_mode && !trst_wr && !mod_wr && !soft_init |=> $stable(count))
    else $error("count moved in stop");
  a_debug_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    debug_active && !trst_wr && !mod_wr && !soft_init |=> $stable(count))
    else $error("count moved in debug");
  a_blind_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow_flag && sc_wr && !flag_seen && !trst_wr |=> overflow_flag)
    else $error("flag cleared without read");
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow_flag && overflow_irq_enable && !stop_exit_reset |=> timer_irq)
    else $error("irq missing");
  a_bus_ticks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && source_select == 2'b00 && prescale_select == 4'h0 |-> tick)
    else $error("divide by one missed");
  a_stop_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_exit_reset |=> counter_halt && count == 8'h00 && wrap_limit == 8'h00)
    else $error("stop reset incomplete");
  // read-back shape of status and release of the request line
  a_status_shape: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pready && !pwrite && paddr == modulo_timer_pkg::status_control_off |-> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
    else $error("status read shape wrong");
  a_irq_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !overflow_flag |=> !timer_irq)
    else $error("irq held without flag");
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n) wrap_now && wrap_limit != 8'h00);
  c_free: cover property (@(posedge sys_clk) disable iff (!rst_n) wrap_now && wrap_limit == 8'h00);
  c_pin: cover property (@(posedge sys_clk) disable iff (!rst_n) tick && source_select[1]);
  c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) flag_clr);

endmodule
`default_nettype wire

/* testbench/modulo_timer_pin_source.sv */
// model of the external count source on the timer clock pins
`default_nettype none
module modulo_timer_pin_source (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [9:0] n_edges,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left;
  logic [1:0] ph;
  // =====================================
  // pulse train generator
  // idle low between trains, like a gated source
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left = 10'h000;
    ph = 2'h0;
  end
  always @(posedge sys_clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      left <= n_edges;
      ph <= 2'h0;
    end else if (busy) begin
      ph <= ph + 2'h1;
      if (ph[0]) begin
        pin <= ~pin;
        if (pin) left <= left - 10'h001;
        if (pin && left == 10'h001) busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/modulo_timer_timer_bench.sv */
// self-checking bench for the modulo timer
`default_nettype none
module modulo_timer_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] scr = modulo_timer_pkg::status_control_off;
  localparam logic [3:0] ccf = modulo_timer_pkg::clock_config_off;
  localparam logic [3:0] cnt = modulo_timer_pkg::count_value_off;
  localparam logic [3:0] wrp = modulo_timer_pkg::wrap_limit_off;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, timer_irq;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr, pin, fclk, stop_mode, stop_exit_reset, debug_active;
  logic [1:0] st;
  wire [1:0] bsy;
  logic [9:0] nn;
  int n_errors, n_checks, cyc;
  // =====================================
  // design and far-side sources
  modulo_timer_timer dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(pin), .fixed_freq_clock(fclk),
    .stop_mode(stop_mode), .stop_exit_reset(stop_exit_reset),
    .debug_active(debug_active), .timer_irq(timer_irq));
  modulo_timer_pin_source pin_src (.sys_clk(sys_clk), .start(st[0]), .n_edges(nn), .pin(pin),
    .busy(bsy[0]));
  modulo_timer_pin_source fix_src (.sys_clk(sys_clk), .start(st[1]), .n_edges(nn), .pin(fclk),
    .busy(bsy[1]));
  // =====================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // generous ceiling, the run needs under ten thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  // =====================================
  // shared tasks
  task end_of_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // setup then access, held until pready is sampled high
  task apb(input logic [3:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle budget here, the hang guard ends a missing answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this step
    @(posedge sys_clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    check(rdat, {24'h00_0000, e});
  endtask
  task irq_is(input logic e);
    check({31'h0000_0000, timer_irq}, {31'h0000_0000, e});
  endtask
  // f high picks the fixed clock source, low the pin; waits out the synchroniser
  task pulse(input logic f, input logic [9:0] n);
    st <= f ? 2'h2 : 2'h1;
    nn <= n;
    @(posedge sys_clk);
    st <= 2'h0;
    @(posedge sys_clk);
    while (bsy !== 2'h0) begin
      @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask
  // =====================================
  // scenarios
  task t_reset();
    rd(scr, 8'h10);
    rd(ccf, 8'h00);
    rd(cnt, 8'h00);
    rd(wrp, 8'h00);
    wr(cnt, 8'hff);
    rd(cnt, 8'h00);
    wr(scr, 8'h3f);
    rd(scr, 8'h10);
    apb(4'h1, 1'b0, 8'h00);
    check({31'h0000_0000, rerr}, 32'h0000_0001);
  endtask
  task t_sources();
    for (int s = 1; s < 4; s++) begin
      wr(ccf, {2'h0, s[1:0], 4'h0});
      wr(scr, 8'h20);
      pulse(s == 1, 10'h005);
      pulse(s != 1, 10'h003);
      rd(cnt, 8'h05);
      wr(scr, 8'h10);
    end
  endtask
  task t_prescale();
    int n;
    for (int c = 0; c < 10; c++) begin
      n = (c > 8) ? 256 : (1 << c);
      wr(ccf, {4'h3, c[3:0]});
      wr(scr, 8'h20);
      if (n > 1) begin
        pulse(1'b0, 10'(n - 1));
        rd(cnt, 8'h00);
      end
      pulse(1'b0, 10'h001);
      rd(cnt, 8'h01);
    end
  endtask
  task t_bus();
    // divide by one: runs from the edge after the start write through the halt write
    wr(ccf, 8'h00);
    wr(scr, 8'h20);
    wr(scr, 8'h10);
    rd(cnt, 8'h03);
    wr(ccf, 8'h08);
    wr(scr, 8'h20);
    repeat (300) @(posedge sys_clk);
    wr(scr, 8'h10);
    rd(cnt, 8'h01);
  endtask
  task t_wrap();
    wr(ccf, 8'h30);
    wr(wrp, 8'h03);
    wr(scr, 8'h00);
    pulse(1'b0, 10'h003);
    rd(cnt, 8'h03);
    rd(scr, 8'h00);
    pulse(1'b0, 10'h001);
    wr(scr, 8'h00);
    rd(cnt, 8'h00);
    rd(scr, 8'h80);
    irq_is(1'b0);
    wr(scr, 8'h00);
    rd(scr, 8'h00);
    // flag is clear before the enable goes up
    wr(scr, 8'h40);
    pulse(1'b0, 10'h004);
    rd(scr, 8'hc0);
    irq_is(1'b1);
    wr(wrp, 8'h05);
    rd(scr, 8'h40);
    irq_is(1'b0);
    rd(cnt, 8'h00);
    pulse(1'b0, 10'h008);
    wr(scr, 8'h60);
    rd(scr, 8'h40);
    rd(cnt, 8'h00);
    wr(wrp, 8'h00);
    pulse(1'b0, 10'h0ff);
    rd(cnt, 8'hff);
    pulse(1'b0, 10'h001);
    rd(cnt, 8'h00);
    rd(scr, 8'hc0);
  endtask
  task t_modes();
    wr(wrp, 8'h09);
    wr(scr, 8'h00);
    stop_mode <= 1'b1;
    pulse(1'b0, 10'h003);
    rd(cnt, 8'h00);
    stop_mode <= 1'b0;
    pulse(1'b0, 10'h002);
    rd(cnt, 8'h02);
    debug_active <= 1'b1;
    pulse(1'b0, 10'h003);
    rd(cnt, 8'h02);
    debug_active <= 1'b0;
    wr(scr, 8'h10);
    pulse(1'b0, 10'h002);
    rd(cnt, 8'h02);
    wr(scr, 8'h00);
    pulse(1'b0, 10'h001);
    wr(ccf, 8'h25);
    rd(cnt, 8'h03);
    stop_exit_reset <= 1'b1;
    @(posedge sys_clk);
    stop_exit_reset <= 1'b0;
    rd(scr, 8'h10);
    rd(ccf, 8'h00);
    rd(wrp, 8'h00);
    rd(cnt, 8'h00);
  endtask
  // =====================================
  // main sequence
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 4'h0;
    pwdata = 32'h0000_0000;
    {stop_mode, stop_exit_reset, debug_active} = 3'h0;
    st = 2'h0;
    nn = 10'h000;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_sources();
    t_prescale();
    t_bus();
    t_wrap();
    t_modes();
    end_of_test();
  end
endmodule
`default_nettype wire
